// File: drive_monitor_dac_output.sv
// two-channel monitor selector, scaler and 8-bit converter code generator
// assumes one clock, synchronous reset; converter stalls via dacReady
// What this block does
// R1: each channel has its own selection; matching quantity is routed to it
// R2: code 0 gives speed meter on channel one, load meter on channel two
// R3: codes 2 and 3 give current command and feedback, 4096 is full rating
// R4: code 4 gives speed feedback in revolutions per minute
// R5: codes 6..9 give droop and position change halves, low then high
// R6: codes 10..13 give position command and feedback halves
// R7: codes 80..83 control inputs, 84..87 control outputs, one bit per signal
// R8: packed bit n contributes two to the power n; set bits add
// R9: each channel scales by its own gain over 256
// R10: other quantities map signed -128..+127 onto mid-scale code 128
// R11: meter quantities use their own unsigned mapping, not mid-scale
// R12: channel two matches channel one beyond code 0; overflow saturates
`timescale 1ns/1ps
`default_nettype none
module drive_monitor_dac_output #(
    parameter int DATA_W = 32
) (
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              srst,
    // channel settings
    input  wire logic [7:0]        chan1DataSelect,
    input  wire logic [7:0]        chan2DataSelect,
    input  wire logic [15:0]       chan1Gain,
    input  wire logic [15:0]       chan2Gain,
    // monitored quantities
    input  wire logic [7:0]        speedMeter,
    input  wire logic [7:0]        loadMeter,
    input  wire logic [15:0]       currentCommand,
    input  wire logic [15:0]       currentFeedback,
    input  wire logic [15:0]       speedFeedback,
    input  wire logic [DATA_W-1:0] positionDroop,
    input  wire logic [DATA_W-1:0] positionDelta,
    input  wire logic [DATA_W-1:0] positionCommand,
    input  wire logic [DATA_W-1:0] positionFeedback,
    input  wire logic [63:0]       controlInputs,
    input  wire logic [63:0]       controlOutputs,
    // converter side
    output logic [7:0]             dac1Code,
    output logic [7:0]             dac2Code,
    output logic                   dacValid,
    input  wire logic              dacReady
);
    localparam int HALF = DATA_W / 2;
    localparam int NCH  = 2;

    // channel settings gathered for the per-channel loop
    wire logic [NCH-1:0][7:0]  selArr   = {chan2DataSelect, chan1DataSelect};
    wire logic [NCH-1:0][15:0] gainArr  = {chan2Gain, chan1Gain};
    wire logic [NCH-1:0][7:0]  meterArr = {loadMeter, speedMeter}; // R2
    wire logic [NCH-1:0][7:0]  codeArr;
    wire logic [NCH-1:0][31:0] rawArr;

    // quantities shared by both channels, sign-extended to the raw width
    wire logic signed [31:0] curCmdRaw  = 32'(signed'(currentCommand)); // R3
    wire logic signed [31:0] curFbRaw   = 32'(signed'(currentFeedback)); // R3
    wire logic signed [31:0] speedFbRaw = 32'(signed'(speedFeedback)); // R4
    wire logic signed [31:0] droopLoRaw = 32'(signed'(positionDroop[HALF-1:0])); // R5
    wire logic signed [31:0] droopHiRaw = 32'(signed'(positionDroop[DATA_W-1:HALF])); // R5
    wire logic signed [31:0] deltaLoRaw = 32'(signed'(positionDelta[HALF-1:0])); // R5
    wire logic signed [31:0] deltaHiRaw = 32'(signed'(positionDelta[DATA_W-1:HALF])); // R5
    wire logic signed [31:0] pcmdLoRaw  = 32'(signed'(positionCommand[HALF-1:0])); // R6
    wire logic signed [31:0] pcmdHiRaw  = 32'(signed'(positionCommand[DATA_W-1:HALF])); // R6
    wire logic signed [31:0] pfbLoRaw   = 32'(signed'(positionFeedback[HALF-1:0])); // R6
    wire logic signed [31:0] pfbHiRaw   = 32'(signed'(positionFeedback[DATA_W-1:HALF])); // R6

    // per-channel select, scale, offset and clamp
    for (genvar ch = 0; ch < NCH; ch++) begin : g_chan
        wire logic [7:0]         sel      = selArr[ch];
        wire logic [15:0]        gain     = gainArr[ch];
        wire logic [7:0]         ctrlIdx  = sel - dac_monitor_pkg::SEL_CIN_BASE;
        wire logic               isCtrl   = (sel >= dac_monitor_pkg::SEL_CIN_BASE)
                                            && (sel <= dac_monitor_pkg::SEL_CTRL_LAST);
        wire logic               isCout   = sel >= dac_monitor_pkg::SEL_COUT_BASE;
        wire logic [63:0]        ctrlBank = isCout ? controlOutputs : controlInputs; // R7
        // bit n of a packed word weighs 2**n, so set bits add
        wire logic [15:0]        ctrlWord = ctrlBank[16*ctrlIdx[1:0] +: 16]; // R7 R8
        wire logic               isMeter  = sel == dac_monitor_pkg::SEL_METER;
        wire logic signed [31:0] raw;

        // codes outside the table give zero, shown as mid-scale
        assign raw = (sel == dac_monitor_pkg::SEL_METER)      ? 32'(meterArr[ch]) // R2
                   : (sel == dac_monitor_pkg::SEL_CUR_CMD)    ? curCmdRaw // R3
                   : (sel == dac_monitor_pkg::SEL_CUR_FB)     ? curFbRaw // R3
                   : (sel == dac_monitor_pkg::SEL_SPEED_FB)   ? speedFbRaw // R4
                   : (sel == dac_monitor_pkg::SEL_DROOP_LO)   ? droopLoRaw // R5
                   : (sel == dac_monitor_pkg::SEL_DROOP_HI)   ? droopHiRaw // R5
                   : (sel == dac_monitor_pkg::SEL_DELTA_LO)   ? deltaLoRaw // R5
                   : (sel == dac_monitor_pkg::SEL_DELTA_HI)   ? deltaHiRaw // R5
                   : (sel == dac_monitor_pkg::SEL_PCMD_LO)    ? pcmdLoRaw // R6
                   : (sel == dac_monitor_pkg::SEL_PCMD_HI)    ? pcmdHiRaw // R6
                   : (sel == dac_monitor_pkg::SEL_PFB_LO)     ? pfbLoRaw // R6
                   : (sel == dac_monitor_pkg::SEL_PFB_HI)     ? pfbHiRaw // R6
                   : isCtrl                                   ? 32'(ctrlWord) // R7 R8
                   : 32'sh0000_0000;
        assign rawArr[ch] = raw; // R1 R12

        wire logic signed [48:0] product   = 49'(raw) * 49'(signed'({1'b0, gain}));
        wire logic signed [48:0] scaled    = product >>> dac_monitor_pkg::GAIN_SHIFT; // R9
        wire logic               meterLow  = scaled < 49'sd0;
        wire logic               meterHigh = scaled > 49'sd255;
        wire logic               sigHigh   = scaled > 49'sd127;
        wire logic               sigLow    = scaled < -49'sd128;

        // meters use their own unsigned mapping with no offset
        wire logic [7:0] meterCode  = meterLow ? 8'h00
                                    : meterHigh ? 8'hFF : scaled[7:0]; // R11
        wire logic [7:0] signedCode = sigLow ? 8'h00
                                    : sigHigh ? 8'hFF : scaled[7:0] + dac_monitor_pkg::MID_CODE; // R10 R12
        assign codeArr[ch] = isMeter ? meterCode : signedCode; // R11
    end : g_chan

    wire logic signed [31:0] raw1     = rawArr[0];
    wire logic signed [31:0] raw2     = rawArr[1];
    wire logic [7:0]         code1    = codeArr[0];
    wire logic [7:0]         code2    = codeArr[1];
    wire logic               isMeter1 = chan1DataSelect == dac_monitor_pkg::SEL_METER;
    wire logic               isMeter2 = chan2DataSelect == dac_monitor_pkg::SEL_METER;

    // two-entry path: the output register plus one parked pair
    logic             skidValid;
    logic [15:0]      skidPair;
    wire logic [15:0] freshPair = {code1, code2};
    wire logic        outFree   = dacReady || !dacValid;
    wire logic        inReady   = !skidValid;
    wire logic        parkFresh = inReady && !outFree;
    wire logic        drainSkid = skidValid && outFree;
    wire logic [15:0] nextPair  = skidValid ? skidPair : freshPair;

    // a stalled converter parks one pair; later samples are dropped
    always_ff @(posedge core_clk) begin
        if (srst) begin
            skidValid <= 1'b0;
            skidPair  <= 16'h0000;
        end else if (parkFresh) begin
            skidValid <= 1'b1;
            skidPair  <= freshPair;
        end else if (drainSkid) begin
            skidValid <= 1'b0;
        end
    end

    // codes leave only from flops; they hold while the converter stalls
    always_ff @(posedge core_clk) begin
        if (srst) begin
            dac1Code <= dac_monitor_pkg::MID_CODE;
            dac2Code <= dac_monitor_pkg::MID_CODE;
            dacValid <= 1'b0;
        end else if (outFree) begin
            dac1Code <= nextPair[15:8];
            dac2Code <= nextPair[7:0];
            dacValid <= 1'b1;
        end
    end

    // mapping checks
    property p_mid_zero;
        @(posedge core_clk) disable iff (srst)
        (!isMeter1 && raw1 == 32'sh0000_0000)
        |-> code1 == dac_monitor_pkg::MID_CODE;
    endproperty
    a_mid_zero: assert property (p_mid_zero) else $error("zero not at mid code"); // R10

    property p_sat;
        @(posedge core_clk) disable iff (srst)
        (!isMeter1 && raw1 > 32'sd127 && chan1Gain == 16'h0100)
        |-> code1 == 8'hFF;
    endproperty
    a_sat: assert property (p_sat) else $error("no saturation high"); // R12

    property p_sat_low;
        @(posedge core_clk) disable iff (srst)
        (!isMeter1 && raw1 < -32'sd128 && chan1Gain == 16'h0100)
        |-> code1 == 8'h00;
    endproperty
    a_sat_low: assert property (p_sat_low) else $error("no saturation low"); // R12

    property p_meter;
        @(posedge core_clk) disable iff (srst)
        (isMeter2 && chan2Gain == 16'h0100)
        |-> code2 == loadMeter;
    endproperty
    a_meter: assert property (p_meter) else $error("meter mapping wrong"); // R11

    property p_meter_speed;
        @(posedge core_clk) disable iff (srst)
        (isMeter1 && chan1Gain == 16'h0100)
        |-> code1 == speedMeter;
    endproperty
    a_meter_speed: assert property (p_meter_speed) else $error("speed meter wrong"); // R2

    property p_gain_unity;
        @(posedge core_clk) disable iff (srst)
        (!isMeter2 && chan2Gain == 16'h0100 && raw2 >= -32'sd128 && raw2 <= 32'sd127)
        |-> code2 == 8'(raw2) + dac_monitor_pkg::MID_CODE;
    endproperty
    a_gain_unity: assert property (p_gain_unity) else $error("unity gain wrong"); // R9

    property p_ctrl_bit;
        @(posedge core_clk) disable iff (srst)
        (chan1DataSelect == dac_monitor_pkg::SEL_CTRL_LAST && chan1Gain == 16'h0100
         && controlOutputs[63:48] == 16'h0010)
        |-> code1 == 8'h90;
    endproperty
    a_ctrl_bit: assert property (p_ctrl_bit) else $error("bit weight wrong"); // R8

    // converter handshake checks
    property p_hold;
        @(posedge core_clk) disable iff (srst)
        (dacValid && !dacReady)
        |=> dacValid && $stable(dac1Code) && $stable(dac2Code);
    endproperty
    a_hold: assert property (p_hold) else $error("stalled word changed");

    property p_refill;
        @(posedge core_clk) disable iff (srst)
        !dacValid
        |=> dacValid;
    endproperty
    a_refill: assert property (p_refill) else $error("no sample after idle");

    property p_route_cmd;
        @(posedge core_clk) disable iff (srst)
        chan1DataSelect == dac_monitor_pkg::SEL_CUR_CMD
        |-> raw1 == 32'(signed'(currentCommand));
    endproperty
    a_route_cmd: assert property (p_route_cmd) else $error("current command not routed"); // R3

    property p_route_fb;
        @(posedge core_clk) disable iff (srst)
        chan1DataSelect == dac_monitor_pkg::SEL_CUR_FB
        |-> raw1 == 32'(signed'(currentFeedback));
    endproperty
    a_route_fb: assert property (p_route_fb) else $error("current feedback not routed"); // R3

    property p_route_speed;
        @(posedge core_clk) disable iff (srst)
        chan1DataSelect == dac_monitor_pkg::SEL_SPEED_FB
        |-> raw1 == 32'(signed'(speedFeedback));
    endproperty
    a_route_speed: assert property (p_route_speed) else $error("speed not routed"); // R4

    property p_route_droop_lo;
        @(posedge core_clk) disable iff (srst)
        chan1DataSelect == dac_monitor_pkg::SEL_DROOP_LO
        |-> raw1 == 32'(signed'(positionDroop[HALF-1:0]));
    endproperty
    a_route_droop_lo: assert property (p_route_droop_lo) else $error("droop low wrong"); // R5

    property p_route_droop_hi;
        @(posedge core_clk) disable iff (srst)
        chan1DataSelect == dac_monitor_pkg::SEL_DROOP_HI
        |-> raw1 == 32'(signed'(positionDroop[DATA_W-1:HALF]));
    endproperty
    a_route_droop_hi: assert property (p_route_droop_hi) else $error("droop high wrong"); // R5

    property p_route_delta_lo;
        @(posedge core_clk) disable iff (srst)
        chan1DataSelect == dac_monitor_pkg::SEL_DELTA_LO
        |-> raw1 == 32'(signed'(positionDelta[HALF-1:0]));
    endproperty
    a_route_delta_lo: assert property (p_route_delta_lo) else $error("delta low wrong"); // R5

    property p_route_delta_hi;
        @(posedge core_clk) disable iff (srst)
        chan1DataSelect == dac_monitor_pkg::SEL_DELTA_HI
        |-> raw1 == 32'(signed'(positionDelta[DATA_W-1:HALF]));
    endproperty
    a_route_delta_hi: assert property (p_route_delta_hi) else $error("delta high wrong"); // R5

    property p_route_pcmd_lo;
        @(posedge core_clk) disable iff (srst)
        chan1DataSelect == dac_monitor_pkg::SEL_PCMD_LO
        |-> raw1 == 32'(signed'(positionCommand[HALF-1:0]));
    endproperty
    a_route_pcmd_lo: assert property (p_route_pcmd_lo) else $error("command low wrong"); // R6

    property p_route_pcmd_hi;
        @(posedge core_clk) disable iff (srst)
        chan1DataSelect == dac_monitor_pkg::SEL_PCMD_HI
        |-> raw1 == 32'(signed'(positionCommand[DATA_W-1:HALF]));
    endproperty
    a_route_pcmd_hi: assert property (p_route_pcmd_hi) else $error("command high wrong"); // R6

    property p_route_pfb_lo;
        @(posedge core_clk) disable iff (srst)
        chan1DataSelect == dac_monitor_pkg::SEL_PFB_LO
        |-> raw1 == 32'(signed'(positionFeedback[HALF-1:0]));
    endproperty
    a_route_pfb_lo: assert property (p_route_pfb_lo) else $error("feedback low wrong"); // R6

    property p_route_pfb_hi;
        @(posedge core_clk) disable iff (srst)
        chan1DataSelect == dac_monitor_pkg::SEL_PFB_HI
        |-> raw1 == 32'(signed'(positionFeedback[DATA_W-1:HALF]));
    endproperty
    a_route_pfb_hi: assert property (p_route_pfb_hi) else $error("feedback high wrong"); // R6

    property p_route_cin;
        @(posedge core_clk) disable iff (srst)
        chan1DataSelect == dac_monitor_pkg::SEL_CIN_BASE
        |-> raw1 == 32'(controlInputs[15:0]);
    endproperty
    a_route_cin: assert property (p_route_cin) else $error("control input wrong"); // R7

    property p_route_cout;
        @(posedge core_clk) disable iff (srst)
        chan2DataSelect == dac_monitor_pkg::SEL_COUT_BASE
        |-> raw2 == 32'(controlOutputs[15:0]);
    endproperty
    a_route_cout: assert property (p_route_cout) else $error("control output wrong"); // R7

    property p_route_cout_last;
        @(posedge core_clk) disable iff (srst)
        chan2DataSelect == dac_monitor_pkg::SEL_CTRL_LAST
        |-> raw2 == 32'(controlOutputs[63:48]);
    endproperty
    a_route_cout_last: assert property (p_route_cout_last) else $error("last word wrong"); // R7

    property p_route_ch2_speed;
        @(posedge core_clk) disable iff (srst)
        chan2DataSelect == dac_monitor_pkg::SEL_SPEED_FB
        |-> raw2 == 32'(signed'(speedFeedback));
    endproperty
    a_route_ch2_speed: assert property (p_route_ch2_speed) else $error("channel two speed"); // R12

    property p_route_ch2_cmd;
        @(posedge core_clk) disable iff (srst)
        chan2DataSelect == dac_monitor_pkg::SEL_CUR_CMD
        |-> raw2 == 32'(signed'(currentCommand));
    endproperty
    a_route_ch2_cmd: assert property (p_route_ch2_cmd) else $error("channel two command"); // R1
endmodule : drive_monitor_dac_output
`default_nettype wire

// File: dac_monitor_pkg.sv
// constants for the two-channel monitor output selector
// assumes the monitor quantities arrive as plain words on the drive clock
package dac_monitor_pkg;
    localparam int SEL_W = 8;
    localparam int GAIN_W = 16;
    localparam int DAC_W = 8;
    localparam logic [7:0] SEL_METER = 8'h00;
    localparam logic [7:0] SEL_CUR_CMD = 8'h02;
    localparam logic [7:0] SEL_CUR_FB = 8'h03;
    localparam logic [7:0] SEL_SPEED_FB = 8'h04;
    localparam logic [7:0] SEL_DROOP_LO = 8'h06;
    localparam logic [7:0] SEL_DROOP_HI = 8'h07;
    localparam logic [7:0] SEL_DELTA_LO = 8'h08;
    localparam logic [7:0] SEL_DELTA_HI = 8'h09;
    localparam logic [7:0] SEL_PCMD_LO = 8'h0A;
    localparam logic [7:0] SEL_PCMD_HI = 8'h0B;
    localparam logic [7:0] SEL_PFB_LO = 8'h0C;
    localparam logic [7:0] SEL_PFB_HI = 8'h0D;
    localparam logic [7:0] SEL_CIN_BASE = 8'h50;
    localparam logic [7:0] SEL_COUT_BASE = 8'h54;
    localparam logic [7:0] SEL_CTRL_LAST = 8'h57;
    localparam int GAIN_SHIFT = 8;
    localparam logic [7:0] MID_CODE = 8'h80;
    localparam logic [7:0] GAIN_RESET = 8'h00;
    localparam logic [7:0] SEL_RESET = 8'h00;
    localparam int PERCENT_FULL = 4096;
    localparam int POS_FULL_TURN = 23040000;
endpackage : dac_monitor_pkg

// File: dac_sink_model.sv
// behavioural converter sink that takes code pairs and can stall
// assumes one clock; ready moves only at falling edges
`timescale 1ns/1ps
`default_nettype none
module dac_sink_model (
    // clock and stall request
    input  wire logic   core_clk,
    input  wire logic   stall,
    // converter side
    input  wire logic   dacValid,
    output var logic    dacReady = 1'b0,
    output var logic [15:0] pairsTaken = 16'h0000
);
    always @(negedge core_clk) dacReady <= !stall;
    always @(posedge core_clk) if (dacValid && dacReady) pairsTaken <= pairsTaken + 16'h0001;
endmodule : dac_sink_model
`default_nettype wire

// File: drive_monitor_dac_output_tb.sv
// self-checking bench for the two-channel monitor selector
// assumes the design and dac_sink_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module drive_monitor_dac_output_tb;
    logic        core_clk = 1'b0, srst = 1'b1, stall = 1'b0, dacValid, dacReady;
    logic [7:0]  chan1DataSelect = 8'h00, chan2DataSelect = 8'h00, dac1Code, dac2Code;
    logic [7:0]  speedMeter = 8'hC8, loadMeter = 8'h64;
    logic [15:0] chan1Gain = 16'h0100, chan2Gain = 16'h0010, pairsTaken;
    logic [15:0] currentCommand = 16'h1333, currentFeedback = 16'hFF38, speedFeedback = 16'h07D0;
    logic [31:0] positionDroop = 32'h0000_1900, positionDelta = 32'hFFFE_0010;
    logic [31:0] positionCommand = 32'h0003_0005, positionFeedback = 32'h0001_FFFF;
    logic [63:0] controlInputs = 64'h0008_0004_0002_0001, controlOutputs = 64'h0010_0040_0020_0010;
    logic [7:0]  codes [22] = '{8'h00, 8'h02, 8'h03, 8'h04, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A,
        8'h0B, 8'h0C, 8'h0D, 8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55, 8'h56, 8'h57, 8'h05, 8'h58};
    int          err_total = 0, num_checks = 0, cycles = 0;
    drive_monitor_dac_output #(.DATA_W(32)) drive_monitor_dac_output_inst (.core_clk, .srst,
        .chan1DataSelect, .chan2DataSelect, .chan1Gain, .chan2Gain, .speedMeter, .loadMeter,
        .currentCommand, .currentFeedback, .speedFeedback, .positionDroop, .positionDelta,
        .positionCommand, .positionFeedback, .controlInputs, .controlOutputs, .dac1Code,
        .dac2Code, .dacValid, .dacReady);
    dac_sink_model dac_sink_model_inst (.core_clk, .stall, .dacValid, .dacReady, .pairsTaken);
    always #50 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 4000) begin
            err_total++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : give_verdict
    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check8
    function automatic logic signed [16:0] sx(input logic [15:0] v);
        return {v[15], v};
    endfunction : sx
    function automatic logic signed [16:0] raw_of(input logic [7:0] c, input bit ch2);
        logic [31:0] p [4];
        logic [63:0] w;
        p = '{positionDroop, positionDelta, positionCommand, positionFeedback};
        w = c[2] ? controlOutputs : controlInputs;
        if (c == 8'h00) return ch2 ? {9'h000, loadMeter} : {9'h000, speedMeter};
        if (c == 8'h02) return sx(currentCommand);
        if (c == 8'h03) return sx(currentFeedback);
        if (c == 8'h04) return sx(speedFeedback);
        if (c >= 8'h06 && c <= 8'h0D) return sx(p[(c - 8'h06) >> 1][16 * c[0] +: 16]);
        if (c >= 8'h50 && c <= 8'h57) return sx(w[16 * c[1:0] +: 16]);
        return 17'sh00000;
    endfunction : raw_of
    function automatic logic [7:0] expect_code(input logic signed [16:0] raw,
                                               input logic [15:0] g, input bit meter);
        logic signed [40:0] p;
        p = (raw * $signed({1'b0, g})) >>> 8;
        if (meter) return p < 0 ? 8'h00 : p > 255 ? 8'hFF : p[7:0];
        return p < -128 ? 8'h00 : p > 127 ? 8'hFF : p[7:0] + 8'h80;
    endfunction : expect_code
    // both channels on different codes, every code once per channel
    task automatic test_select(input logic [15:0] g1, input logic [15:0] g2);
        chan1Gain = g1;
        chan2Gain = g2;
        foreach (codes[i]) begin
            chan1DataSelect = codes[i];
            chan2DataSelect = codes[21 - i];
            repeat (6) @(negedge core_clk);
            check8("valid", 8'h01, {7'h00, dacValid});
            check8("ch1", expect_code(raw_of(codes[i], 0), g1, codes[i] == 8'h00), dac1Code);
            check8("ch2", expect_code(raw_of(codes[21 - i], 1), g2, codes[21 - i] == 8'h00), dac2Code);
        end
        $display("test_select done");
    endtask : test_select
    task automatic test_stall();
        logic [7:0]  held;
        logic [15:0] taken;
        chan1DataSelect = 8'h02;
        repeat (6) @(negedge core_clk);
        stall = 1'b1;
        repeat (3) @(negedge core_clk);
        held = dac1Code;
        taken = pairsTaken;
        chan1DataSelect = 8'h04;
        repeat (6) @(negedge core_clk);
        check8("stall valid", 8'h01, {7'h00, dacValid});
        check8("stall hold", held, dac1Code);
        check8("stall taken", taken[7:0], pairsTaken[7:0]);
        stall = 1'b0;
        repeat (6) @(negedge core_clk);
        check8("after stall", expect_code(sx(speedFeedback), chan1Gain, 0), dac1Code);
        $display("test_stall done");
    endtask : test_stall
    initial begin
        repeat (5) @(negedge core_clk);
        check8("reset ch1", 8'h80, dac1Code);
        check8("reset valid", 8'h00, {7'h00, dacValid});
        srst = 1'b0;
        test_select(16'h0100, 16'h0010);
        test_select(16'h0006, 16'h0100);
        test_stall();
        give_verdict();
    end
endmodule : drive_monitor_dac_output_tb
`default_nettype wire
